// ==== inc/cmd_pkg.sv ====
// constants, command codes and state codes shared by the command handling block
package cmd_pkg;
	typedef enum logic [3:0] {
		CMD_INTACK = 4'h0,
		CMD_SPECIAL = 4'h1,
		CMD_IO_RD = 4'h2,
		CMD_IO_WR = 4'h3,
		CMD_RSV4 = 4'h4,
		CMD_RSV5 = 4'h5,
		CMD_MEM_RD = 4'h6,
		CMD_MEM_WR = 4'h7,
		CMD_RSV8 = 4'h8,
		CMD_RSV9 = 4'h9,
		CMD_CFG_RD = 4'hA,
		CMD_CFG_WR = 4'hB,
		CMD_MEM_RD_MULT = 4'hC,
		CMD_DAC = 4'hD,
		CMD_MEM_RD_LINE = 4'hE,
		CMD_MEM_WR_INV = 4'hF
	} cmd_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_DEC = 3'h1,
		ST_DATA = 3'h3,
		ST_TURN = 3'h2,
		ST_DAC = 3'h4
	} tstate_t;

	localparam int unsigned MAX_WAIT_DEF = 16;
	localparam int unsigned WAIT_W = 5;
	localparam int unsigned CFG_WORDS = 16;
	localparam int unsigned CFG_IDX_W = 4;
	localparam int unsigned CFG_IDX_LSB = 2;
	localparam logic [3:0] CFG_LOAD_IDX = 4'hE;
	localparam logic [3:0] CFG_RB_IDX = 4'hF;
	// identity word: arbitrary value
	localparam logic [31:0] CFG_ID_WORD = 32'h00A5005A;
	localparam logic [31:0] CFG_ZERO = 32'h00000000;
	localparam logic [3:0] BE_ALL_ON_N = 4'h0;
	localparam logic [31:0] ADDR_STEP = 32'h00000004;
endpackage : cmd_pkg

// ==== inc/policy_if.sv ====
// command policy carried from the decoder to its user
`timescale 1ns/100ps
interface policy_if;
	logic [3:0] code;
	logic accept;
	logic rd;
	logic wr;
	logic io;
	logic mem;
	logic cfg;
	logic burst;
	logic dac;
	modport dec (input code, output accept, rd, wr, io, mem, cfg, burst, dac);
	modport use_p (output code, input accept, rd, wr, io, mem, cfg, burst, dac);
endinterface : policy_if

// ==== design/cmd_decode.sv ====
// decodes a 4-bit bus command into its transfer policy
`timescale 1ns/100ps
module cmd_decode (
	policy_if.dec pol
);
	wire is_mrd;
	wire is_mwr;
	wire is_io;
	wire is_cfg;
	assign is_mrd = (pol.code == cmd_pkg::CMD_MEM_RD) || (pol.code == cmd_pkg::CMD_MEM_RD_MULT)
		|| (pol.code == cmd_pkg::CMD_MEM_RD_LINE);
	assign is_mwr = (pol.code == cmd_pkg::CMD_MEM_WR) || (pol.code == cmd_pkg::CMD_MEM_WR_INV);
	assign is_io = (pol.code == cmd_pkg::CMD_IO_RD) || (pol.code == cmd_pkg::CMD_IO_WR);
	assign is_cfg = (pol.code == cmd_pkg::CMD_CFG_RD) || (pol.code == cmd_pkg::CMD_CFG_WR);
	assign pol.accept = is_mrd | is_mwr | is_io | is_cfg;
	assign pol.rd = is_mrd || (pol.code == cmd_pkg::CMD_IO_RD) || (pol.code == cmd_pkg::CMD_CFG_RD);
	assign pol.wr = is_mwr || (pol.code == cmd_pkg::CMD_IO_WR) || (pol.code == cmd_pkg::CMD_CFG_WR);
	assign pol.io = is_io;
	assign pol.mem = is_mrd | is_mwr;
	assign pol.cfg = is_cfg;
	assign pol.burst = is_mrd | is_mwr;
	assign pol.dac = (pol.code == cmd_pkg::CMD_DAC);
endmodule : cmd_decode

// ==== design/pci_command_handling.sv ====
// target command policy, delayed transactions, config space and master command issue
// What this block does
// - interrupt acknowledge is never issued nor claimed
// - special cycles are ignored by target and never issued
// - reserved command codes are never claimed nor issued
// - I/O accesses disconnect with data on the first data phase
// - delay mode low: I/O and memory reads are delayed, no wait states
// - delay mode high: I/O and memory reads wait for user data, retry at the wait limit
// - delay mode low: I/O writes are delayed, no wait states
// - delay mode high: memory reads burst; pending but empty waits up to the limit, then retry
// - memory writes are posted, burst, and see no wait states
// - config accesses never burst, no waits, disconnect with first data
// - config accesses are served internally, user logic sees nothing
// - master permits bursts and adds no wait states of its own
// - read multiple is handled as a plain memory read
// - read line is handled as a plain memory read
// - write and invalidate is handled as a plain memory write
// - a dual address with zero upper half becomes a single address
// - default config contents answer correctly straight after reset
// - logic configuration may be loaded through config writes
// - logic configuration may be read back through config reads
// - device select asserts two clocks after the address phase
// - master reads drive all byte enables; target ignores read enables
`timescale 1ns/100ps
module pci_command_handling #(
	parameter int unsigned MAX_WAIT = cmd_pkg::MAX_WAIT_DEF,
	parameter logic [31:0] MEM_BASE = 32'h80000000,
	parameter logic [31:0] MEM_MASK = 32'hFFF00000,
	parameter logic [31:0] IO_BASE = 32'h00001000,
	parameter logic [31:0] IO_MASK = 32'hFFFFFF00
) (
	input wire logic REF_CLK,
	input wire logic RESETN,
	input wire logic FRAME_N,
	input wire logic IRDY_N,
	input wire logic IDSEL,
	input wire logic [31:0] AD_IN,
	input wire logic [3:0] CBE_IN,
	output logic [31:0] AD_OUT,
	output logic AD_OE,
	output logic DEVSEL_N_OUT,
	output logic TRDY_N_OUT,
	output logic STOP_N_OUT,
	output logic TGT_OE,
	input wire logic DELTR_N,
	input wire logic TR_PEND_N,
	input wire logic TR_VALID,
	input wire logic [31:0] TR_DATA,
	output logic TR_TAKE,
	output logic TW_VALID,
	output logic [31:0] TW_ADDR,
	output logic [31:0] TW_DATA,
	output logic [3:0] TW_BE,
	output logic DLY_REQ,
	output logic [3:0] DLY_CMD,
	output logic [31:0] DLY_ADDR,
	output logic [31:0] DLY_WDATA,
	output logic [3:0] DLY_BE,
	input wire logic DLY_ACK,
	input wire logic [31:0] DLY_RDATA,
	output logic CFG_LOAD_STB,
	output logic [31:0] CFG_LOAD_DATA,
	input wire logic [31:0] CFG_RB_DATA,
	input wire logic MST_GO,
	input wire logic [3:0] MST_CMD,
	input wire logic [63:0] MST_ADDR,
	input wire logic [3:0] MST_BE,
	output logic MST_ISSUE,
	output logic [3:0] MST_ISSUE_CMD,
	output logic [63:0] MST_ISSUE_ADDR,
	output logic MST_ISSUE_DAC,
	output logic [3:0] MST_ISSUE_BE,
	output logic MST_BURST_OK,
	output logic MST_REFUSED
);
	localparam logic [cmd_pkg::WAIT_W-1:0] WAIT_LAST = cmd_pkg::WAIT_W'(MAX_WAIT - 1);

	// bus pins come from the bus clock domain: two flops before use
	logic [37:0] sync1_q;
	logic [37:0] sync2_q;
	wire frame_s = sync2_q[37];
	wire irdy_s = sync2_q[36];
	wire idsel_s = sync2_q[35];
	wire [31:0] ad_s = sync2_q[31:0];
	wire [2:0] cbe_s = sync2_q[34:32];
	always_ff @(posedge REF_CLK) begin
		sync1_q <= {FRAME_N, IRDY_N, IDSEL, CBE_IN[2:0], AD_IN};
		sync2_q <= sync1_q;
	end
	logic cbe3_1_q;
	logic cbe3_2_q;
	always_ff @(posedge REF_CLK) begin
		cbe3_1_q <= CBE_IN[3];
		cbe3_2_q <= cbe3_1_q;
	end
	wire [3:0] cbe_full = {cbe3_2_q, cbe_s[2:0]};

	cmd_pkg::tstate_t st_q;
	logic [3:0] cmd_q;
	logic [31:0] addr_q;
	logic upper_zero_q;
	logic idsel_q;

	policy_if tp ();
	policy_if mp ();
	assign tp.code = cmd_q;
	assign mp.code = MST_CMD;
	cmd_decode u_tdec (.pol(tp.dec));
	cmd_decode u_mdec (.pol(mp.dec));

	// claim decode, evaluated in the decode cycle
	wire mem_hit = ((addr_q & MEM_MASK) == MEM_BASE) && tp.mem;
	wire io_hit = ((addr_q & IO_MASK) == IO_BASE) && tp.io;
	wire cfg_hit = tp.cfg && idsel_q;
	wire claim = tp.accept && upper_zero_q && (mem_hit || io_hit || cfg_hit);
	// delayed handling selected by the strap input
	wire use_dly = ~DELTR_N && ((tp.rd && !tp.cfg) || (tp.io && tp.wr));
	logic dly_pend_q;
	logic dly_done_q;
	logic [31:0] dly_rdata_q;
	wire dly_match = (cmd_q == DLY_CMD) && (addr_q == DLY_ADDR);
	wire dly_finish = use_dly && dly_pend_q && dly_done_q && dly_match;
	wire dly_start = use_dly && claim && !dly_pend_q;

	// config space with default contents from reset onward
	logic [31:0] cfg_mem_q [cmd_pkg::CFG_WORDS];
	wire [cmd_pkg::CFG_IDX_W-1:0] cfg_idx =
		addr_q[cmd_pkg::CFG_IDX_LSB +: cmd_pkg::CFG_IDX_W];
	// readback word taken from the configuration logic
	wire [31:0] cfg_rd_word = (cfg_idx == cmd_pkg::CFG_RB_IDX) ? CFG_RB_DATA : cfg_mem_q[cfg_idx];
	wire [31:0] be_mask = {{8{~cbe_full[3]}}, {8{~cbe_full[2]}}, {8{~cbe_full[1]}}, {8{~cbe_full[0]}}};

	// data phase flags
	logic m_cfg_q;
	logic m_rd_q;
	logic m_post_q;
	logic m_dly_q;
	logic m_one_q;
	logic m_burst_q;
	logic got_one_q;
	logic [cmd_pkg::WAIT_W-1:0] wait_q;
	wire xfer = ~irdy_s && ~TRDY_N_OUT;
	wire done = frame_s && (xfer || ~STOP_N_OUT);
	wire rd_stream = (st_q == cmd_pkg::ST_DATA) && m_rd_q && !m_cfg_q && !m_dly_q;
	wire can_load = rd_stream && STOP_N_OUT && (TRDY_N_OUT || (xfer && m_burst_q)) && !done;
	wire load = can_load && TR_VALID;
	wire at_limit = (wait_q == WAIT_LAST);
	wire drained = got_one_q && !TR_VALID && TR_PEND_N;
	wire give_up = rd_stream && STOP_N_OUT && TRDY_N_OUT && !TR_VALID && (at_limit || drained);

	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			st_q <= cmd_pkg::ST_IDLE;
			cmd_q <= 4'h0;
			addr_q <= 32'h00000000;
			upper_zero_q <= 1'b1;
			idsel_q <= 1'b0;
		end else begin
			unique case (st_q)
				cmd_pkg::ST_IDLE: begin
					if (!frame_s) begin
						cmd_q <= cbe_full;
						addr_q <= ad_s;
						idsel_q <= idsel_s;
						upper_zero_q <= 1'b1;
						st_q <= (cbe_full == cmd_pkg::CMD_DAC) ? cmd_pkg::ST_DAC : cmd_pkg::ST_DEC;
					end
				end
				cmd_pkg::ST_DAC: begin
					// zero upper half falls back to 32-bit decode
					cmd_q <= cbe_full;
					upper_zero_q <= (ad_s == 32'h00000000);
					st_q <= cmd_pkg::ST_DEC;
				end
				cmd_pkg::ST_DEC: begin
					st_q <= claim ? cmd_pkg::ST_DATA : cmd_pkg::ST_TURN;
				end
				cmd_pkg::ST_DATA: begin
					if (done) begin
						st_q <= cmd_pkg::ST_TURN;
					end
				end
				cmd_pkg::ST_TURN: begin
					// unclaimed cycles wait here for the master to finish
					if (frame_s && irdy_s) begin
						st_q <= cmd_pkg::ST_IDLE;
					end
				end
				default: st_q <= cmd_pkg::ST_IDLE;
			endcase
		end
	end

	// target handshake outputs
	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			DEVSEL_N_OUT <= 1'b1;
			TRDY_N_OUT <= 1'b1;
			STOP_N_OUT <= 1'b1;
			TGT_OE <= 1'b0;
			AD_OE <= 1'b0;
			AD_OUT <= 32'h00000000;
			m_cfg_q <= 1'b0;
			m_rd_q <= 1'b0;
			m_post_q <= 1'b0;
			m_dly_q <= 1'b0;
			m_one_q <= 1'b0;
			m_burst_q <= 1'b0;
			got_one_q <= 1'b0;
			wait_q <= '0;
		end else if (st_q == cmd_pkg::ST_DEC && claim) begin
			// medium decode: select two clocks after address
			DEVSEL_N_OUT <= 1'b0;
			TGT_OE <= 1'b1;
			AD_OE <= tp.rd;
			m_cfg_q <= tp.cfg;
			m_rd_q <= tp.rd;
			m_post_q <= tp.mem && tp.wr;
			m_dly_q <= use_dly;
			m_one_q <= tp.io || tp.cfg;
			m_burst_q <= tp.burst;
			got_one_q <= 1'b0;
			wait_q <= '0;
			if (tp.cfg) begin
				// config: no wait, disconnect with data
				TRDY_N_OUT <= 1'b0;
				STOP_N_OUT <= 1'b0;
				AD_OUT <= cfg_rd_word;
			end else if (use_dly) begin
				// retry until done, then one word
				TRDY_N_OUT <= ~dly_finish;
				STOP_N_OUT <= 1'b0;
				AD_OUT <= dly_rdata_q;
			end else if (tp.mem && tp.wr) begin
				// no wait states on posted writes
				TRDY_N_OUT <= 1'b0;
			end else if (tp.io && tp.wr) begin
				TRDY_N_OUT <= 1'b0;
				STOP_N_OUT <= 1'b0;
			end
		end else if (st_q == cmd_pkg::ST_DATA) begin
			if (done) begin
				DEVSEL_N_OUT <= 1'b1;
				TRDY_N_OUT <= 1'b1;
				STOP_N_OUT <= 1'b1;
				AD_OE <= 1'b0;
			end else if (load) begin
				// data from user ends the wait
				AD_OUT <= TR_DATA;
				TRDY_N_OUT <= 1'b0;
				// I/O read disconnects with its first word
				STOP_N_OUT <= ~m_one_q;
				got_one_q <= 1'b1;
				wait_q <= '0;
			end else if (give_up) begin
				// wait limit reached, or user has nothing more pending: retry or disconnect
				STOP_N_OUT <= 1'b0;
			end else if (xfer && !m_post_q) begin
				TRDY_N_OUT <= 1'b1;
			end else if (rd_stream && TRDY_N_OUT) begin
				wait_q <= wait_q + 1'b1;
			end
		end else if (st_q == cmd_pkg::ST_TURN) begin
			// release the shared lines one cycle after driving them high
			TGT_OE <= 1'b0;
		end
	end

	// user-side strobes for streamed transfers
	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			TR_TAKE <= 1'b0;
			TW_VALID <= 1'b0;
			TW_ADDR <= 32'h00000000;
			TW_DATA <= 32'h00000000;
			TW_BE <= 4'h0;
		end else begin
			TR_TAKE <= load;
			// posted burst words handed on as they arrive
			TW_VALID <= (st_q == cmd_pkg::ST_DATA) && m_post_q && xfer;
			TW_DATA <= ad_s;
			TW_BE <= cbe_full;
			if (st_q == cmd_pkg::ST_DEC) begin
				TW_ADDR <= addr_q;
			end else if (TW_VALID) begin
				TW_ADDR <= TW_ADDR + cmd_pkg::ADDR_STEP;
			end
		end
	end

	// delayed transaction bookkeeping
	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			dly_pend_q <= 1'b0;
			dly_done_q <= 1'b0;
			dly_rdata_q <= 32'h00000000;
			DLY_REQ <= 1'b0;
			DLY_CMD <= 4'h0;
			DLY_ADDR <= 32'h00000000;
			DLY_WDATA <= 32'h00000000;
			DLY_BE <= 4'h0;
		end else begin
			if (st_q == cmd_pkg::ST_DEC && dly_start) begin
				dly_pend_q <= 1'b1;
				DLY_CMD <= cmd_q;
				DLY_ADDR <= addr_q;
			end else if (st_q == cmd_pkg::ST_DEC && claim && dly_finish) begin
				dly_pend_q <= 1'b0;
				dly_done_q <= 1'b0;
			end else if (DLY_ACK && dly_pend_q) begin
				dly_done_q <= 1'b1;
				dly_rdata_q <= DLY_RDATA;
			end
			// write data of the retried attempt is latched once master is ready
			if (st_q == cmd_pkg::ST_DATA && m_dly_q && TRDY_N_OUT && !irdy_s) begin
				DLY_WDATA <= ad_s;
				DLY_BE <= cbe_full;
			end
			DLY_REQ <= dly_pend_q && !dly_done_q;
		end
	end

	// config writes served inside the core only
	wire cfg_wr_now = (st_q == cmd_pkg::ST_DATA) && m_cfg_q && !m_rd_q && xfer;
	// load port word goes to the configuration logic
	wire cfg_load_now = cfg_wr_now && (cfg_idx == cmd_pkg::CFG_LOAD_IDX);
	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			for (int i = 0; i < cmd_pkg::CFG_WORDS; i++) begin
				cfg_mem_q[i] <= (i == 0) ? cmd_pkg::CFG_ID_WORD : cmd_pkg::CFG_ZERO;
			end
			CFG_LOAD_STB <= 1'b0;
			CFG_LOAD_DATA <= 32'h00000000;
		end else begin
			CFG_LOAD_STB <= cfg_load_now;
			if (cfg_load_now) begin
				CFG_LOAD_DATA <= ad_s;
			end else if (cfg_wr_now && cfg_idx != '0) begin
				cfg_mem_q[cfg_idx] <= (cfg_mem_q[cfg_idx] & ~be_mask) | (ad_s & be_mask);
			end
		end
	end

	// master command issue
	wire mst_upper_zero = (MST_ADDR[63:32] == 32'h00000000);
	// dual address code is a legal master command too
	wire mst_ok = mp.accept || mp.dac;
	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			MST_ISSUE <= 1'b0;
			MST_ISSUE_CMD <= 4'h0;
			MST_ISSUE_ADDR <= 64'h0000000000000000;
			MST_ISSUE_DAC <= 1'b0;
			MST_ISSUE_BE <= 4'h0;
			MST_BURST_OK <= 1'b0;
			MST_REFUSED <= 1'b0;
		end else begin
			// forbidden codes never reach the bus
			MST_ISSUE <= MST_GO && mst_ok;
			MST_REFUSED <= MST_GO && !mst_ok;
			if (MST_GO && mst_ok) begin
				MST_ISSUE_CMD <= MST_CMD;
				MST_ISSUE_ADDR <= MST_ADDR;
				// dual address only when upper half is used
				MST_ISSUE_DAC <= !mst_upper_zero && mp.mem;
				// every byte enable asserted on reads
				MST_ISSUE_BE <= mp.rd ? cmd_pkg::BE_ALL_ON_N : MST_BE;
				// bursting allowed, no master wait states
				MST_BURST_OK <= 1'b1;
			end
		end
	end
endmodule : pci_command_handling

// ==== testbench/pci_command_handling_asserts.sv ====
// port-level checks for the command handling block
`timescale 1ns/100ps
module pci_command_handling_asserts (
	input wire logic REF_CLK,
	input wire logic RESETN,
	input wire logic DEVSEL_N_OUT,
	input wire logic TRDY_N_OUT,
	input wire logic TGT_OE,
	input wire logic TR_TAKE,
	input wire logic TW_VALID,
	input wire logic DLY_REQ,
	input wire logic [3:0] DLY_CMD,
	input wire logic MST_ISSUE,
	input wire logic [3:0] MST_ISSUE_CMD,
	input wire logic [63:0] MST_ISSUE_ADDR,
	input wire logic MST_ISSUE_DAC,
	input wire logic [3:0] MST_ISSUE_BE,
	input wire logic MST_BURST_OK
);
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RESETN);
	property p_claim_drives;
		(!DEVSEL_N_OUT || !TRDY_N_OUT) |-> TGT_OE;
	endproperty
	a_claim_drives: assert property (p_claim_drives)
		else $error("target strobe low without output enable");
	property p_trdy_claimed;
		!TRDY_N_OUT |-> !DEVSEL_N_OUT;
	endproperty
	a_trdy_claimed: assert property (p_trdy_claimed)
		else $error("ready without device select");
	property p_pending_no_data;
		DLY_REQ |-> TRDY_N_OUT;
	endproperty
	a_pending_no_data: assert property (p_pending_no_data)
		else $error("data phase while delayed request unanswered");
	property p_delayed_kind;
		$rose(DLY_REQ) |-> DLY_CMD inside {4'h2, 4'h3, 4'h6, 4'hC, 4'hE};
	endproperty
	a_delayed_kind: assert property (p_delayed_kind)
		else $error("delayed request for wrong command");
	property p_post_after_xfer;
		TW_VALID |-> $past(!TRDY_N_OUT);
	endproperty
	a_post_after_xfer: assert property (p_post_after_xfer)
		else $error("posted word without data transfer");
	property p_take_after_load;
		TR_TAKE |-> !TRDY_N_OUT;
	endproperty
	a_take_after_load: assert property (p_take_after_load)
		else $error("read word taken without transfer");
	property p_legal_issue;
		MST_ISSUE |-> !(MST_ISSUE_CMD inside {4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9});
	endproperty
	a_legal_issue: assert property (p_legal_issue)
		else $error("master issued a forbidden command");
	property p_burst_kept;
		MST_ISSUE |-> ##1 MST_BURST_OK [*3];
	endproperty
	a_burst_kept: assert property (p_burst_kept)
		else $error("burst permission missing after issue");
	property p_dac_upper;
		(MST_ISSUE && MST_ISSUE_DAC) |-> MST_ISSUE_ADDR[63:32] != 32'h0;
	endproperty
	a_dac_upper: assert property (p_dac_upper)
		else $error("dual address with zero upper half");
	property p_read_be;
		(MST_ISSUE && MST_ISSUE_CMD inside {4'h2, 4'h6, 4'hA, 4'hC, 4'hE})
			|-> MST_ISSUE_BE == cmd_pkg::BE_ALL_ON_N;
	endproperty
	a_read_be: assert property (p_read_be)
		else $error("master read without all byte enables");
endmodule : pci_command_handling_asserts
bind pci_command_handling pci_command_handling_asserts pci_command_handling_asserts_i (
	.REF_CLK, .RESETN, .DEVSEL_N_OUT, .TRDY_N_OUT, .TGT_OE, .TR_TAKE, .TW_VALID, .DLY_REQ,
	.DLY_CMD, .MST_ISSUE, .MST_ISSUE_CMD, .MST_ISSUE_ADDR, .MST_ISSUE_DAC, .MST_ISSUE_BE,
	.MST_BURST_OK
);

// ==== testbench/bus_master_model.sv ====
// behavioural bus master making single data phase transfers
`timescale 1ns/100ps
module bus_master_model (
	input wire logic clk,
	input wire logic devsel_n,
	input wire logic trdy_n,
	input wire logic stop_n,
	input wire logic [31:0] rd_bus,
	output logic frame_n,
	output logic irdy_n,
	output logic idsel,
	output logic [31:0] ad,
	output logic [3:0] cbe
);
	initial begin
		frame_n = 1'b1;
		irdy_n = 1'b1;
		idsel = 1'b0;
		ad = 32'h5A5A5A5A;
		cbe = 4'hF;
	end
	task automatic xfer(input logic [3:0] cmd, input logic [31:0] addr, input logic [31:0] wd,
			input logic sel, output logic cl, output logic tr, output logic st,
			output logic [31:0] rd);
		int n;
		cl = 1'b0;
		n = 0;
		@(posedge clk);
		#2;
		frame_n = 1'b0;
		ad = addr;
		cbe = cmd;
		idsel = sel;
		@(posedge clk);
		#2;
		frame_n = 1'b1;
		irdy_n = 1'b0;
		ad = wd;
		cbe = 4'h0;
		idsel = 1'b0;
		do begin
			@(posedge clk);
			n++;
			if (!devsel_n) cl = 1'b1;
		end while (n < 40 && trdy_n && stop_n);
		tr = !trdy_n;
		st = !stop_n;
		rd = rd_bus;
		#2;
		irdy_n = 1'b1;
		// a released bus must not look like it still holds the data
		ad = ~wd;
		cbe = 4'hF;
		repeat (6) @(posedge clk);
		#2;
	endtask : xfer
endmodule : bus_master_model

// ==== testbench/pci_command_handling_bench.sv ====
// self-checking bench for the command handling block
`timescale 1ns/100ps
module pci_command_handling_bench;
	localparam logic [31:0] MEMA = 32'h80000010;
	localparam logic [31:0] IOA = 32'h00001004;
	localparam logic [31:0] RBW = 32'h3C3C0F0F;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic deltr_n = 1'b1;
	logic pend_n = 1'b1;
	logic tr_valid = 1'b0;
	logic dly_ack = 1'b0;
	logic mst_go = 1'b0;
	logic [31:0] tr_data = 32'h0;
	logic [31:0] dly_rdata = 32'h0;
	logic [3:0] mst_cmd = 4'h0;
	logic [3:0] mst_be = 4'h0;
	logic [63:0] mst_addr = 64'h0;
	logic frame_n, irdy_n, idsel, devsel_n, trdy_n, stop_n, tw_valid, dly_req, load_stb;
	logic mst_issue, mst_dac, refused, c, t, s;
	logic [3:0] cbe, dly_cmd, iss_be;
	logic [31:0] ad, ad_out, tw_addr, tw_data, dly_addr, dly_wdata, load_data, r;
	logic [31:0] tw_last, tw_alast, load_last;
	int error_cnt = 0;
	int checks_done = 0;
	int cycles = 0;
	int tw_cnt = 0;
	int iss_cnt = 0;
	int ref_cnt = 0;
	always #12.5 clk = ~clk;
	pci_command_handling #(.MAX_WAIT(6)) pci_command_handling_i (
		.REF_CLK(clk), .RESETN(rst_n), .FRAME_N(frame_n), .IRDY_N(irdy_n), .IDSEL(idsel),
		.AD_IN(ad), .CBE_IN(cbe), .AD_OUT(ad_out), .AD_OE(), .DEVSEL_N_OUT(devsel_n),
		.TRDY_N_OUT(trdy_n), .STOP_N_OUT(stop_n), .TGT_OE(), .DELTR_N(deltr_n),
		.TR_PEND_N(pend_n), .TR_VALID(tr_valid), .TR_DATA(tr_data), .TR_TAKE(),
		.TW_VALID(tw_valid), .TW_ADDR(tw_addr), .TW_DATA(tw_data), .TW_BE(),
		.DLY_REQ(dly_req), .DLY_CMD(dly_cmd), .DLY_ADDR(dly_addr), .DLY_WDATA(dly_wdata),
		.DLY_BE(), .DLY_ACK(dly_ack), .DLY_RDATA(dly_rdata), .CFG_LOAD_STB(load_stb),
		.CFG_LOAD_DATA(load_data), .CFG_RB_DATA(RBW), .MST_GO(mst_go), .MST_CMD(mst_cmd),
		.MST_ADDR(mst_addr), .MST_BE(mst_be), .MST_ISSUE(mst_issue), .MST_ISSUE_CMD(),
		.MST_ISSUE_ADDR(), .MST_ISSUE_DAC(mst_dac), .MST_ISSUE_BE(iss_be),
		.MST_BURST_OK(), .MST_REFUSED(refused)
	);
	bus_master_model bus_master_model_i (
		.clk(clk), .devsel_n(devsel_n), .trdy_n(trdy_n), .stop_n(stop_n), .rd_bus(ad_out),
		.frame_n(frame_n), .irdy_n(irdy_n), .idsel(idsel), .ad(ad), .cbe(cbe)
	);
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (tw_valid === 1'b1) begin
			tw_cnt <= tw_cnt + 1;
			tw_last <= tw_data;
			tw_alast <= tw_addr;
		end
		if (load_stb === 1'b1) load_last <= load_data;
		if (mst_issue === 1'b1) iss_cnt <= iss_cnt + 1;
		if (refused === 1'b1) ref_cnt <= ref_cnt + 1;
		if (cycles == 20000) begin
			error_cnt++;
			end_sim();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic end_sim();
		$display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : end_sim
	task automatic x(input logic [3:0] cm, input logic [31:0] a, w, input logic sl);
		bus_master_model_i.xfer(cm, a, w, sl, c, t, s, r);
	endtask : x
	task automatic ack(input logic [31:0] d);
		@(posedge clk);
		#2;
		dly_rdata = d;
		dly_ack = 1'b1;
		@(posedge clk);
		#2;
		dly_ack = 1'b0;
	endtask : ack
	task automatic t_config();
		int n0;
		n0 = tw_cnt;
		x(cmd_pkg::CMD_CFG_RD, 32'h0, 32'h0, 1'b1);
		check(r, cmd_pkg::CFG_ID_WORD);
		check({t, s}, 2'b11);
		x(cmd_pkg::CMD_CFG_WR, 32'h38, 32'hC0DE1234, 1'b1);
		check(load_last, 32'hC0DE1234);
		check({t, s}, 2'b11);
		check(tw_cnt - n0, 0);
		x(cmd_pkg::CMD_CFG_RD, 32'h3C, 32'h0, 1'b1);
		check(r, RBW);
		x(cmd_pkg::CMD_CFG_RD, 32'h0, 32'h0, 1'b0);
		check(c, 1'b0);
	endtask : t_config
	task automatic t_ignore();
		logic [3:0] bad [6] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9};
		foreach (bad[i]) begin
			x(bad[i], MEMA, 32'h0, 1'b1);
			check(c, 1'b0);
		end
	endtask : t_ignore
	task automatic t_write();
		logic [3:0] wc [2] = '{cmd_pkg::CMD_MEM_WR, cmd_pkg::CMD_MEM_WR_INV};
		int n0;
		for (int i = 0; i < 2; i++) begin
			n0 = tw_cnt;
			x(wc[i], MEMA, 32'hA0000000 + i, 1'b0);
			check({c, t, s}, 3'b110);
			check(tw_cnt - n0, 1);
			check(tw_last, 32'hA0000000 + i);
			check(tw_alast, MEMA);
		end
	endtask : t_write
	task automatic t_read();
		logic [3:0] rc [4] = '{cmd_pkg::CMD_IO_RD, cmd_pkg::CMD_MEM_RD,
			cmd_pkg::CMD_MEM_RD_MULT, cmd_pkg::CMD_MEM_RD_LINE};
		int n;
		pend_n = 1'b0;
		for (int i = 0; i < 4; i++) begin
			tr_data = 32'hD0000000 + i;
			fork
				x(rc[i], (i == 0) ? IOA : MEMA, 32'h0, 1'b0);
				begin
					n = 0;
					while (devsel_n !== 1'b0 && n < 40) begin
						@(posedge clk);
						n++;
					end
					// late data forces the target to hold wait states
					repeat (2) @(posedge clk);
					#2;
					tr_valid = 1'b1;
				end
			join
			tr_valid = 1'b0;
			check(r, tr_data);
			check({t, s}, {1'b1, i == 0});
		end
		x(cmd_pkg::CMD_MEM_RD, MEMA, 32'h0, 1'b0);
		check({t, s}, 2'b01);
		pend_n = 1'b1;
	endtask : t_read
	task automatic t_delay();
		deltr_n = 1'b0;
		x(cmd_pkg::CMD_IO_RD, IOA, 32'h0, 1'b0);
		check({t, s, dly_req}, 3'b011);
		check(dly_cmd, cmd_pkg::CMD_IO_RD);
		check(dly_addr, IOA);
		ack(32'h600DF00D);
		x(cmd_pkg::CMD_IO_RD, IOA, 32'h0, 1'b0);
		check({t, s, dly_req}, 3'b110);
		check(r, 32'h600DF00D);
		x(cmd_pkg::CMD_IO_WR, IOA, 32'h12345678, 1'b0);
		check({t, s, dly_req}, 3'b011);
		check(dly_wdata, 32'h12345678);
		ack(32'h0);
		deltr_n = 1'b1;
	endtask : t_delay
	task automatic t_master();
		int i0;
		int r0;
		logic bad;
		for (int k = 0; k < 16; k++) begin
			bad = k inside {0, 1, 4, 5, 8, 9};
			i0 = iss_cnt;
			r0 = ref_cnt;
			mst_cmd = 4'(k);
			mst_addr = {(k == 6) ? 32'h1 : 32'h0, 32'h100};
			mst_be = 4'h3;
			mst_go = 1'b1;
			@(posedge clk);
			#2;
			mst_go = 1'b0;
			repeat (3) @(posedge clk);
			#2;
			check(ref_cnt - r0, bad);
			check(iss_cnt - i0, !bad);
			if (!bad && k != 13) check(mst_dac, k == 6);
			if (k inside {2, 6, 10, 12, 14}) check(iss_be, cmd_pkg::BE_ALL_ON_N);
		end
	endtask : t_master
	initial begin
		repeat (3) @(posedge clk);
		#2;
		rst_n = 1'b1;
		repeat (3) @(posedge clk);
		#2;
		check({devsel_n, trdy_n, stop_n, dly_req}, 4'b1110);
		t_config();
		t_ignore();
		t_write();
		t_read();
		t_delay();
		t_master();
		end_sim();
	end
endmodule : pci_command_handling_bench
